// *** rtl/pzc_pkg.sv ***
// package of constants for the port zero pin control block
//
// Contract
// - pin levels always feed interrupt circuit
// - pull-up bit one connects pull-up
// - driven low pin drops its pull-up
// - group one enabled when enable-bar zero
// - group one disabled when enable-bar one
// - group two needs both bits zero
// - group two disabled by either bit
// - normal data read returns pin state
// - read-modify-write read returns output latch
// - other registers except status read back last write
// - direction one drives latch, zero inputs
// - reset clears all direction bits
package pzc_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] PZC_OFS_DATA    = 8'h00;  // port_zero_pin_data, normal read
  localparam logic [7:0] PZC_OFS_DIR     = 8'h04;  // port_zero_direction
  localparam logic [7:0] PZC_OFS_PULL    = 8'h08;  // port_zero_pullup_enable
  localparam logic [7:0] PZC_OFS_AIDIS   = 8'h0c;  // analog_input_disable_low
  localparam logic [7:0] PZC_OFS_CMP     = 8'h10;  // comparator control bits
  localparam logic [7:0] PZC_OFS_DATA_RMW= 8'h14;  // port_zero_pin_data, latch read
  localparam logic [7:0] PZC_OFS_STAT    = 8'h18;  // comparator path status, read only
  // reset values
  localparam logic [7:0] PZC_RST_DATA    = 8'h00;
  localparam logic [7:0] PZC_RST_DIR     = 8'h00;
  localparam logic [7:0] PZC_RST_PULL    = 8'h00;
  localparam logic [7:0] PZC_RST_AIDIS   = 8'h00;
  localparam logic [3:0] PZC_RST_CMP     = 4'h0;
  // comparator control field positions
  localparam int PZC_CMP_CH0_EN_N = 0;   // ch zero analog input enable, active low
  localparam int PZC_CMP_CH0_NSEL = 1;   // ch zero negative source select
  localparam int PZC_CMP_CH1_EN_N = 2;   // ch one analog input enable, active low
  localparam int PZC_CMP_CH1_NSEL = 3;   // ch one negative source select
  // comparator pin positions within the port
  localparam int PZC_PIN_G1_CH0 = 0;     // port_zero_bit_zero, group one
  localparam int PZC_PIN_G2_CH0 = 1;     // port_zero_bit_one, group two
  localparam int PZC_PIN_G1_CH1 = 3;     // port_zero_bit_three, group one
  localparam int PZC_PIN_G2_CH1 = 4;     // port_zero_bit_four, group two
  // apb slave states
  typedef enum logic [1:0] {
    PZC_ST_IDLE   = 2'b00,
    PZC_ST_ACCESS = 2'b01,
    PZC_ST_DONE   = 2'b10
  } pzc_apb_state_e;
endpackage

// *** rtl/pzc_pin_cell.sv ***
// one pin of port zero: drive enable and pull-up gating
`timescale 1ns/10ps
`default_nettype none
module pzc_pin_cell
  import pzc_pkg::*;
(
  input  wire logic latch_i,      // output latch bit
  input  wire logic dir_i,        // direction bit, one is output
  input  wire logic pull_i,       // pull-up enable bit
  output logic      pad_out_o,    // value driven to pad
  output logic      pad_oe_n_o,   // pad enable, low while driving
  output logic      pull_on_o     // pull-up connect
);
  // drive the latch only when the pin is an output
  always_comb begin
    pad_out_o  = latch_i;
    pad_oe_n_o = ~dir_i;
    pull_on_o  = pull_i & ~(dir_i & ~latch_i);
  end
endmodule
`default_nettype wire

// *** rtl/pzc_cmp_gate.sv ***
// comparator input path enables for the four comparator pins
`timescale 1ns/10ps
`default_nettype none
module pzc_cmp_gate
  import pzc_pkg::*;
(
  input  wire logic [3:0] cmp_ctrl_i,   // comparator control bits
  output logic      [7:0] cmp_en_o      // per pin comparator path enable
);
  // data and direction take no part here
  always_comb begin
    cmp_en_o = 8'h00;
    cmp_en_o[PZC_PIN_G1_CH0] = ~cmp_ctrl_i[PZC_CMP_CH0_EN_N];
    cmp_en_o[PZC_PIN_G1_CH1] = ~cmp_ctrl_i[PZC_CMP_CH1_EN_N];
    cmp_en_o[PZC_PIN_G2_CH0] = ~(cmp_ctrl_i[PZC_CMP_CH0_EN_N] | cmp_ctrl_i[PZC_CMP_CH0_NSEL]);
    cmp_en_o[PZC_PIN_G2_CH1] = ~(cmp_ctrl_i[PZC_CMP_CH1_EN_N] | cmp_ctrl_i[PZC_CMP_CH1_NSEL]);
  end
endmodule
`default_nettype wire

// *** rtl/pzc_port_zero.sv ***
// port zero pin control top with apb register slave
`timescale 1ns/10ps
`default_nettype none
module pzc_port_zero
  import pzc_pkg::*;
(
  input  wire logic        clk_sys_i,        // system clock, 25 mhz
  input  wire logic        nrst_i,           // synchronous reset, active low
  // apb slave
  input  wire logic        psel_i,           // select
  input  wire logic        penable_i,        // access phase
  input  wire logic        pwrite_i,         // write direction
  input  wire logic [7:0]  paddr_i,          // byte address
  input  wire logic [31:0] pwdata_i,         // write data
  output logic      [31:0] prdata_o,         // read data
  output logic             pready_o,         // transfer done
  output logic             pslverr_o,        // unmapped address
  // pads
  input  wire logic [7:0]  pad_in_i,         // pin levels
  output logic      [7:0]  pad_out_o,        // pin drive values
  output logic      [7:0]  pad_oe_n_o,       // pin enables, low drives
  output logic      [7:0]  pull_on_o,        // pull-up connects
  // peripherals
  output logic      [7:0]  ext_int_lvl_o,    // levels to interrupt circuit
  output logic      [7:0]  cmp_path_en_o,    // comparator input path enables
  output logic      [7:0]  analog_in_en_o    // analog input enable per pin
);
  //////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]      latch_ff;     // output latch
  logic [7:0]      dir_ff;       // direction
  logic [7:0]      pull_ff;      // pull-up enable
  logic [7:0]      aidis_ff;     // analog input disable
  logic [3:0]      cmp_ff;       // comparator control bits
  pzc_apb_state_e  state_ff;     // apb slave state
  pzc_apb_state_e  nxt_state;    // next apb state
  logic [7:0]      pin_out_w;    // cell drive values
  logic [7:0]      pin_oe_n_w;   // cell enables
  logic [7:0]      pin_pull_w;   // cell pull-ups
  logic [7:0]      cmp_en_w;     // comparator gate result
  logic [31:0]     rd_w;         // read mux
  logic            hit_w;        // address mapped
  logic            wr_w;         // write commits this edge

  // address decode, used for write and error
  function automatic logic pzc_mapped(input logic [7:0] a);
    case (a)
      PZC_OFS_DATA, PZC_OFS_DIR, PZC_OFS_PULL, PZC_OFS_AIDIS,
      PZC_OFS_CMP, PZC_OFS_DATA_RMW, PZC_OFS_STAT: pzc_mapped = 1'b1;
      default: pzc_mapped = 1'b0;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // apb state: setup, access, one answer cycle
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      PZC_ST_IDLE: begin
        if (psel_i && penable_i) begin
          nxt_state = PZC_ST_ACCESS;
        end
      end
      PZC_ST_ACCESS: begin
        nxt_state = PZC_ST_DONE;
      end
      PZC_ST_DONE: begin
        nxt_state = PZC_ST_IDLE;
      end
      default: begin
        nxt_state = PZC_ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      state_ff <= PZC_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // write commits on the edge pready is seen high
  assign hit_w = pzc_mapped(paddr_i);
  assign wr_w  = (state_ff == PZC_ST_DONE) && psel_i && penable_i && pwrite_i && hit_w;

  //////////////////////////////////////////////////////////////////////////////
  // control registers
  // eight-bit writes, four-bit for comparator control, next edge
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      latch_ff <= PZC_RST_DATA;
      dir_ff   <= PZC_RST_DIR;
      pull_ff  <= PZC_RST_PULL;
      aidis_ff <= PZC_RST_AIDIS;
      cmp_ff   <= PZC_RST_CMP;
    end else if (wr_w) begin
      case (paddr_i)
        PZC_OFS_DATA, PZC_OFS_DATA_RMW: begin
          latch_ff <= pwdata_i[7:0];
        end
        PZC_OFS_DIR: begin
          dir_ff <= pwdata_i[7:0];
        end
        PZC_OFS_PULL: begin
          pull_ff <= pwdata_i[7:0];
        end
        PZC_OFS_AIDIS: begin
          aidis_ff <= pwdata_i[7:0];
        end
        PZC_OFS_CMP: begin
          cmp_ff <= pwdata_i[3:0];
        end
        default: begin
          latch_ff <= latch_ff;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    rd_w = 32'h0000_0000;
    case (paddr_i)
      PZC_OFS_DATA:     rd_w[7:0] = pad_in_i;
      PZC_OFS_DATA_RMW: rd_w[7:0] = latch_ff;
      PZC_OFS_DIR:      rd_w[7:0] = dir_ff;
      PZC_OFS_PULL:     rd_w[7:0] = pull_ff;
      PZC_OFS_AIDIS:    rd_w[7:0] = aidis_ff;
      PZC_OFS_CMP:      rd_w[3:0] = cmp_ff;
      PZC_OFS_STAT:     rd_w[7:0] = cmp_en_w & ~aidis_ff;
      default:          rd_w = 32'h0000_0000;
    endcase
  end

  // answer registers, pready high one cycle in done state
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= (nxt_state == PZC_ST_DONE);
      pslverr_o <= (nxt_state == PZC_ST_DONE) && !hit_w;
      if (nxt_state == PZC_ST_DONE) begin
        prdata_o <= rd_w;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin cells, one per bit
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      pzc_pin_cell u_cell (
        .latch_i    (latch_ff[gi]),
        .dir_i      (dir_ff[gi]),
        .pull_i     (pull_ff[gi]),
        .pad_out_o  (pin_out_w[gi]),
        .pad_oe_n_o (pin_oe_n_w[gi]),
        .pull_on_o  (pin_pull_w[gi])
      );
    end
  endgenerate

  // comparator path enables
  pzc_cmp_gate u_cmp (
    .cmp_ctrl_i (cmp_ff),
    .cmp_en_o   (cmp_en_w)
  );

  //////////////////////////////////////////////////////////////////////////////
  // registered pin and peripheral outputs
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      pad_out_o      <= 8'h00;
      pad_oe_n_o     <= 8'hff;
      pull_on_o      <= 8'h00;
      ext_int_lvl_o  <= 8'h00;
      cmp_path_en_o  <= 8'h00;
      analog_in_en_o <= 8'h00;
    end else begin
      pad_out_o      <= pin_out_w;
      pad_oe_n_o     <= pin_oe_n_w;
      pull_on_o      <= pin_pull_w;
      ext_int_lvl_o  <= pad_in_i;
      cmp_path_en_o  <= cmp_en_w;
      analog_in_en_o <= ~aidis_ff;
    end
  end
endmodule
`default_nettype wire

// *** tb/pzc_port_zero_monitor.sv ***
// checker on the port zero pin control ports
`timescale 1ns/10ps
`default_nettype none
module pzc_port_zero_monitor
  import pzc_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        nrst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [7:0]  pad_in_i,
  input wire logic [7:0]  pad_out_o,
  input wire logic [7:0]  pad_oe_n_o,
  input wire logic [7:0]  pull_on_o,
  input wire logic [7:0]  ext_int_lvl_o,
  input wire logic [7:0]  cmp_path_en_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  sequence s_req; psel_i && penable_i && !pready_o; endsequence
  sequence s_ans; pready_o ##1 !pready_o; endsequence
  property p_answer; s_req |-> ##[1:2] s_ans; endproperty
  property p_err; pready_o |-> pslverr_o == !(paddr_i inside {[0:24]} && paddr_i[1:0] == 0);
  endproperty
  property p_upper; pready_o && !pwrite_i |-> prdata_o[31:8] == 24'h0; endproperty
  property p_int; $past(nrst_i) |-> ext_int_lvl_o == $past(pad_in_i); endproperty
  property p_pull; (pull_on_o & ~pad_oe_n_o & ~pad_out_o) == 8'h00; endproperty
  property p_grp; (cmp_path_en_o & 8'he4) == 8'h00 && (!cmp_path_en_o[1] || cmp_path_en_o[0])
    && (!cmp_path_en_o[4] || cmp_path_en_o[3]); endproperty
  property p_rst; $rose(nrst_i) |-> pad_oe_n_o == 8'hff && pull_on_o == 8'h00; endproperty
  property p_drive; $changed(pad_out_o) || $changed(pad_oe_n_o)
    |-> $past(pready_o, 2) && $past(pwrite_i, 2); endproperty
  a_answer: assert property (p_answer) else $error("no single pready pulse");
  a_err: assert property (p_err) else $error("pslverr wrong for address");
  a_upper: assert property (p_upper) else $error("upper read bits set");
  a_int: assert property (p_int) else $error("interrupt level not pin level");
  a_pull: assert property (p_pull) else $error("pull-up on low driven pin");
  a_grp: assert property (p_grp) else $error("comparator path group wrong");
  a_rst: assert property (p_rst) else $error("pins not inputs after reset");
  a_drive: assert property (p_drive) else $error("pin drive changed without write");
endmodule
bind pzc_port_zero pzc_port_zero_monitor u_mon (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .pad_in_i(pad_in_i),
  .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o), .pull_on_o(pull_on_o),
  .ext_int_lvl_o(ext_int_lvl_o), .cmp_path_en_o(cmp_path_en_o));
`default_nettype wire

// *** tb/pzc_pin_model.sv ***
// pad model: driven, externally held, pulled up or floating
`timescale 1ns/10ps
`default_nettype none
module pzc_pin_model (
  input wire logic       clk_sys_i,
  input wire logic [7:0] pad_out_i,
  input wire logic [7:0] pad_oe_n_i,
  input wire logic [7:0] pull_on_i,
  input wire logic [7:0] ext_val_i,
  input wire logic [7:0] ext_en_i,
  output logic     [7:0] pad_lvl_o
);
  logic [7:0] float_ff = 8'h55;  // undriven level wanders every cycle
  always_ff @(posedge clk_sys_i) float_ff <= ~float_ff;
  // driver wins, then outside source, then pull-up, else floating
  assign pad_lvl_o = (~pad_oe_n_i & pad_out_i) | (pad_oe_n_i & ext_en_i & ext_val_i)
    | (pad_oe_n_i & ~ext_en_i & (pull_on_i | float_ff));
endmodule
`default_nettype wire

// *** tb/pzc_port_zero_bench.sv ***
// self-checking bench for port zero pin control
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm,e,s) begin comparisons++; if ((e) !== (s)) begin n_errors++; \
  $display("unexpected %s exp %h got %h", nm, e, s); end end
module pzc_port_zero_bench;
  import pzc_pkg::*;
  logic        clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0]  paddr = 0, ext = 0, pin, pad_out, oe_n, pull_on, lvl, cmp_en, ain;
  logic [7:0]  d, l, p, a, ce;
  logic [31:0] pwdata = 0, prdata;
  logic [33:0] q[$], e;
  int          n_errors = 0, comparisons = 0;
  always #20 clk = ~clk;
  pzc_port_zero dut (.clk_sys_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .pad_in_i(pin), .pad_out_o(pad_out),
    .pad_oe_n_o(oe_n), .pull_on_o(pull_on), .ext_int_lvl_o(lvl), .cmp_path_en_o(cmp_en),
    .analog_in_en_o(ain));
  pzc_pin_model u_pins (.clk_sys_i(clk), .pad_out_i(pad_out), .pad_oe_n_i(oe_n),
    .pull_on_i(pull_on), .ext_val_i(ext), .ext_en_i(8'hff), .pad_lvl_o(pin));
  // oldest note against each answer
  always @(posedge clk) if (pready === 1'b1) begin
    e = q.pop_front();
    `CHK("pslverr", e[32], pslverr)
    if (e[33]) `CHK("prdata", e[31:0], prdata)
  end
  task automatic xfer(input logic [7:0] ad, input logic w, input logic [7:0] v, input logic er);
    q.push_back({~w, er, 24'h0, er ? 8'h00 : v});
    psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= {24'h0, v};
    @(posedge clk) penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask
  task summarize;
    if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    summarize();
  end
  initial begin
    void'($urandom(93886));
    repeat (5) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    xfer(PZC_OFS_DIR, 0, 8'h00, 0);
    xfer(PZC_OFS_PULL, 0, 8'h00, 0);
    `CHK("oe_n", 8'hff, oe_n)
    for (int i = 0; i < 16; i++) begin
      {d, l, p, a} = $urandom;
      if (i == 15) {d, l, p} = 24'hff00ff;
      ext <= 8'($urandom);
      xfer(PZC_OFS_DIR, 1, d, 0);
      xfer(i[0] ? PZC_OFS_DATA_RMW : PZC_OFS_DATA, 1, l, 0);
      xfer(PZC_OFS_PULL, 1, p, 0);
      xfer(PZC_OFS_AIDIS, 1, a, 0);
      xfer(PZC_OFS_CMP, 1, 8'(i), 0);
      ce = {3'h0, ~(i[2] | i[3]), ~i[2], 1'b0, ~(i[0] | i[1]), ~i[0]};
      xfer(PZC_OFS_DIR, 0, d, 0);
      xfer(PZC_OFS_AIDIS, 0, a, 0);
      xfer(PZC_OFS_DATA_RMW, 0, l, 0);
      xfer(PZC_OFS_DATA, 0, (d & l) | (~d & ext), 0);
      xfer(PZC_OFS_STAT, 0, ce & ~a, 0);
      `CHK("pad_out", l, pad_out)
      `CHK("oe_n", ~d, oe_n)
      `CHK("pull_on", p & ~(d & ~l), pull_on)
      `CHK("cmp_en", ce, cmp_en)
      `CHK("ain", ~a, ain)
      `CHK("int_lvl", (d & l) | (~d & ext), lvl)
    end
    xfer(8'h20, 1, 8'h5a, 1);
    xfer(8'h20, 0, 8'h00, 1);
    xfer(PZC_OFS_STAT, 1, 8'hff, 0);
    xfer(PZC_OFS_STAT, 0, ce & ~a, 0);
    nrst <= 0;
    repeat (2) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    xfer(PZC_OFS_DIR, 0, 8'h00, 0);
    `CHK("oe_n", 8'hff, oe_n)
    summarize();
  end
endmodule
`default_nettype wire
